// file: diag_monitor_pages.sv
/*
  Extended diagnostics monitor register bank: paged window over
  descriptors, samples, threshold quads, flags, masks and the
  statistics control page, reached over an apb slave.
  Assumes vendor logic loads descriptors and thresholds, feeds
  samples, fine error samples, level statistics and histogram
  bins, all synchronous to pclk.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
// How it works
// - capability bit advertises monitoring support
// - descriptor pages hold 64 slots each
// - sample pages follow descriptor slot order
// - threshold pages hold sixteen quads each
// - one flag page, four flags each
// - mask bits stop flags raising interrupt
// - control page holds freeze, statistics, snr and ltp
// - bank zero populated, other banks read zero except the capability bit
// - two-byte descriptor, zero marks unused slot
// - 64 threshold sets shared by slots
// - descriptor selects the threshold set used
// - absent thresholds default to extreme values
// - four groups, each its page share
// - separate high/low warning and alarm flags
// - statistics kept for fine error samples
// - freeze snapshots results, restarts accumulation
// - eye snr in 1/256 dB units
// - level transition from peaks and valleys
// - peaks between valleys, valleys at thresholds
// - no flags during reset or init
// - all three valleys zero gives all ones, overflow saturates
`timescale 1ns/1ps
module diag_monitor_pages (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        management_init_state,
  input  wire logic        desc_we,
  input  wire logic [7:0]  desc_slot,
  input  wire logic [15:0] desc_value,
  input  wire logic        thr_we,
  input  wire logic [7:0]  thr_index,
  input  wire logic [15:0] thr_value,
  input  wire logic        samp_valid,
  input  wire logic [7:0]  samp_slot,
  input  wire logic [15:0] samp_value,
  input  wire logic        fine_valid,
  input  wire logic [15:0] fine_value,
  input  wire logic        snr_valid,
  input  wire logic [15:0] lvl_mean0,
  input  wire logic [15:0] lvl_mean1,
  input  wire logic [15:0] lvl_mean2,
  input  wire logic [15:0] lvl_mean3,
  input  wire logic [15:0] lvl_sigma0,
  input  wire logic [15:0] lvl_sigma1,
  input  wire logic [15:0] lvl_sigma2,
  input  wire logic [15:0] lvl_sigma3,
  input  wire logic        hist_valid,
  input  wire logic        hist_first,
  input  wire logic        hist_last,
  input  wire logic [7:0]  hist_bin,
  input  wire logic [15:0] hist_count,
  input  wire logic [7:0]  valley_bin0,
  input  wire logic [7:0]  valley_bin1,
  input  wire logic [7:0]  valley_bin2,
  output logic             irq_request,
  output logic      [15:0] electrical_eye_snr,
  output logic      [15:0] level_transition_metric
);
  // storage for bank zero
  logic [15:0] desc  [256];
  logic [15:0] samp  [256];
  logic [15:0] thr   [256];
  logic [3:0]  flag  [256];
  logic [3:0]  mask  [256];

  logic [7:0]  page_sel, next_page_sel;
  logic [1:0]  bank_sel, next_bank_sel;
  logic        err_q, next_err_q;
  logic [31:0] next_prdata;
  logic        frozen, next_frozen;

  // apb decode; the window index is the byte offset minus 128
  logic        setup, access, hit_page, hit_win, wr_ok, rd_ok;
  logic [6:0]  idx;
  logic        bank0;
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign hit_page = paddr == diag_pkg::ADDR_PAGE_SEL;
  assign hit_win  = paddr >= diag_pkg::ADDR_WIN_BASE && paddr <= diag_pkg::ADDR_WIN_LAST
                    && paddr[1:0] == 2'h0;
  assign idx      = paddr[8:2];
  assign bank0    = bank_sel == 2'h0;
  assign wr_ok    = access & pwrite & ~err_q;
  assign rd_ok    = access & ~pwrite & ~err_q;
  // zero wait states: the read byte is captured in the setup cycle
  assign pready   = penable;
  assign pslverr  = penable & err_q;

  // statistics state
  logic [15:0] live_min, live_max, live_avg, snap_min, snap_max, snap_avg;
  logic [31:0] live_sum;
  logic [15:0] live_cnt;

  // byte seen through the window for the selected page
  logic [7:0]  rd_byte;
  logic [7:0]  slot2;
  logic [15:0] w16;
  logic [15:0] st_min, st_max, st_avg;
  assign st_min = frozen ? snap_min : live_min;
  assign st_max = frozen ? snap_max : live_max;
  assign st_avg = frozen ? snap_avg : live_avg;
  always_comb
  begin
    rd_byte = 8'h00;
    slot2   = {page_sel[1:0], idx[6:1]};
    w16     = 16'h0000;
    if (page_sel == diag_pkg::PAGE_ADVERT)
    begin
      if (idx == diag_pkg::ADVERT_BYTE)
        rd_byte[diag_pkg::ADVERT_BIT] = 1'b1;
    end
    else if (!bank0)
      rd_byte = 8'h00;
    else if (page_sel >= diag_pkg::PAGE_DESC0 && page_sel < diag_pkg::PAGE_SAMP0)
    begin
      w16 = desc[slot2];
      rd_byte = idx[0] ? w16[7:0] : w16[15:8];
    end
    else if (page_sel >= diag_pkg::PAGE_SAMP0 && page_sel < diag_pkg::PAGE_THR0)
    begin
      w16 = samp[slot2];
      rd_byte = idx[0] ? w16[7:0] : w16[15:8];
    end
    else if (page_sel >= diag_pkg::PAGE_THR0 && page_sel < diag_pkg::PAGE_FLAG)
    begin
      w16 = thr[{page_sel[1:0], idx[6:1]}];
      rd_byte = idx[0] ? w16[7:0] : w16[15:8];
    end
    else if (page_sel == diag_pkg::PAGE_FLAG)
      rd_byte = {flag[{idx, 1'b1}], flag[{idx, 1'b0}]};
    else if (page_sel == diag_pkg::PAGE_MASK)
      rd_byte = {mask[{idx, 1'b1}], mask[{idx, 1'b0}]};
    else if (page_sel == diag_pkg::PAGE_CTRL)
    begin
      if (idx == diag_pkg::FREEZE_BYTE)
        rd_byte[diag_pkg::FREEZE_BIT] = frozen;
      else if (idx[6:1] == diag_pkg::STAT_BYTE0[6:1])
        rd_byte = idx[0] ? st_min[7:0] : st_min[15:8];
      else if (idx[6:1] == diag_pkg::STAT_BYTE0[6:1] + 6'h01)
        rd_byte = idx[0] ? st_max[7:0] : st_max[15:8];
      else if (idx[6:1] == diag_pkg::STAT_BYTE0[6:1] + 6'h02)
        rd_byte = idx[0] ? st_avg[7:0] : st_avg[15:8];
      else if (idx[6:1] == diag_pkg::SNR_BYTE0[6:1])
        rd_byte = idx[0] ? electrical_eye_snr[7:0] : electrical_eye_snr[15:8];
      else if (idx[6:1] == diag_pkg::LTP_BYTE0[6:1])
        rd_byte = idx[0] ? level_transition_metric[7:0] : level_transition_metric[15:8];
    end
  end

  // apb control registers and read capture
  always_comb
  begin
    next_page_sel = page_sel;
    next_bank_sel = bank_sel;
    next_err_q    = err_q;
    next_prdata   = prdata;
    next_frozen   = frozen;
    if (setup)
    begin
      next_err_q  = !(hit_page || hit_win);
      next_prdata = 32'h00000000;
      if (hit_page)
        next_prdata = {22'h000000, bank_sel, page_sel};
      else if (hit_win)
        next_prdata = {24'h000000, rd_byte};
    end
    if (wr_ok && hit_page)
    begin
      if (pstrb[0])
        next_page_sel = pwdata[7:0];
      if (pstrb[1])
        next_bank_sel = pwdata[diag_pkg::BANK_LSB +: 2];
    end
    if (wr_ok && hit_win && pstrb[0] && page_sel == diag_pkg::PAGE_CTRL && idx == diag_pkg::FREEZE_BYTE)
      next_frozen = pwdata[diag_pkg::FREEZE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_sel <= 8'h00;
      bank_sel <= 2'h0;
      err_q    <= 1'b0;
      prdata   <= 32'h00000000;
      frozen   <= 1'b0;
    end
    else
    begin
      page_sel <= next_page_sel;
      bank_sel <= next_bank_sel;
      err_q    <= next_err_q;
      prdata   <= next_prdata;
      frozen   <= next_frozen;
    end
  end

  // vendor loading of descriptors, thresholds and live samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 256; i++)
      begin
        desc[i] <= 16'h0000;
        samp[i] <= 16'h0000;
        // unused highs sit at max, lows at min, never crossed
        thr[i]  <= i[0] ? diag_pkg::THR_MIN : diag_pkg::THR_MAX;
      end
    end
    else
    begin
      if (desc_we)
        desc[desc_slot] <= desc_value;
      if (thr_we)
        thr[thr_index] <= thr_value;
      if (samp_valid)
        samp[samp_slot] <= samp_value;
    end
  end

  // threshold comparison for the incoming sample
  localparam int SET_W_L = diag_pkg::SET_W;
  logic [SET_W_L-1:0] set_idx;
  logic [3:0]  raise;
  logic        raise_ok;
  assign set_idx  = desc[samp_slot][SET_W_L-1:0];
  assign raise_ok = samp_valid & ~management_init_state
                    & (desc[samp_slot] != 16'h0000);
  always_comb
  begin
    raise = 4'h0;
    raise[diag_pkg::THR_HI_ALARM] = samp_value > thr[{set_idx, diag_pkg::THR_HI_ALARM}];
    raise[diag_pkg::THR_LO_ALARM] = samp_value < thr[{set_idx, diag_pkg::THR_LO_ALARM}];
    raise[diag_pkg::THR_HI_WARN]  = samp_value > thr[{set_idx, diag_pkg::THR_HI_WARN}];
    raise[diag_pkg::THR_LO_WARN]  = samp_value < thr[{set_idx, diag_pkg::THR_LO_WARN}];
  end

  // per-slot flag latch and mask, two slots per window byte
  logic        rd_flag_hit, wr_mask_hit;
  logic [255:0] pend;
  assign rd_flag_hit = rd_ok & hit_win & bank0 & page_sel == diag_pkg::PAGE_FLAG;
  assign wr_mask_hit = wr_ok & hit_win & bank0 & pstrb[0] & page_sel == diag_pkg::PAGE_MASK;
  for (genvar e = 0; e < 256; e++)
  begin : g_slot
    logic [3:0] clr, set, next_flag, next_mask;
    always_comb
    begin
      // clear only what the host was shown; a new set still wins
      clr = (rd_flag_hit && idx == e[7:1]) ? (e[0] ? prdata[7:4] : prdata[3:0]) : 4'h0;
      set = (raise_ok && samp_slot == e[7:0]) ? raise : 4'h0;
      next_flag = (flag[e] & ~clr) | set;
      next_mask = mask[e];
      if (wr_mask_hit && idx == e[7:1])
        next_mask = e[0] ? pwdata[7:4] : pwdata[3:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        flag[e] <= 4'h0;
        mask[e] <= 4'h0;
      end
      else
      begin
        flag[e] <= next_flag;
        mask[e] <= next_mask;
      end
    end
    assign pend[e] = |(flag[e] & ~mask[e]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_request <= 1'b0;
    else
      irq_request <= |pend;
  end

  // min, max and average of the fine error samples
  logic        freeze_rise;
  logic [15:0] next_live_min, next_live_max, next_snap_min, next_snap_max, next_snap_avg;
  logic [31:0] next_live_sum;
  logic [15:0] next_live_cnt;
  assign freeze_rise = next_frozen & ~frozen;
  always_comb
  begin
    next_live_min = live_min;
    next_live_max = live_max;
    next_live_sum = live_sum;
    next_live_cnt = live_cnt;
    next_snap_min = snap_min;
    next_snap_max = snap_max;
    next_snap_avg = snap_avg;
    if (freeze_rise)
    begin
      // close the interval and reopen it in the same cycle
      next_snap_min = live_min;
      next_snap_max = live_max;
      next_snap_avg = live_avg;
      next_live_min = diag_pkg::THR_MAX;
      next_live_max = diag_pkg::THR_MIN;
      next_live_sum = 32'h00000000;
      next_live_cnt = 16'h0000;
    end
    else if (fine_valid && live_cnt != 16'hffff)
    begin
      // count saturates so the 32-bit sum cannot overflow
      if (fine_value < live_min)
        next_live_min = fine_value;
      if (fine_value > live_max)
        next_live_max = fine_value;
      next_live_sum = live_sum + {16'h0000, fine_value};
      next_live_cnt = live_cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      live_min <= diag_pkg::THR_MAX;
      live_max <= diag_pkg::THR_MIN;
      live_sum <= 32'h00000000;
      live_cnt <= 16'h0000;
      snap_min <= diag_pkg::THR_MAX;
      snap_max <= diag_pkg::THR_MIN;
      snap_avg <= 16'h0000;
    end
    else
    begin
      live_min <= next_live_min;
      live_max <= next_live_max;
      live_sum <= next_live_sum;
      live_cnt <= next_live_cnt;
      snap_min <= next_snap_min;
      snap_max <= next_snap_max;
      snap_avg <= next_snap_avg;
    end
  end

  // serial divider refreshing the live average; trades 33 cycles
  // of staleness for not building a wide combinational divide
  diag_pkg::div_state_t div_state, next_div_state;
  logic [31:0] dv_q, next_dv_q;
  logic [16:0] dv_r, next_dv_r, dv_t;
  logic [15:0] dv_d, next_dv_d, next_live_avg;
  logic [5:0]  dv_n, next_dv_n;
  always_comb
  begin
    next_div_state = div_state;
    next_dv_q      = dv_q;
    next_dv_r      = dv_r;
    next_dv_d      = dv_d;
    next_dv_n      = dv_n;
    next_live_avg  = freeze_rise ? 16'h0000 : live_avg;
    dv_t           = {dv_r[15:0], dv_q[31]};
    case (div_state)
      diag_pkg::div_idle:
      begin
        if (live_cnt != 16'h0000)
        begin
          next_dv_q      = live_sum;
          next_dv_d      = live_cnt;
          next_dv_r      = 17'h00000;
          next_dv_n      = 6'h20;
          next_div_state = diag_pkg::div_run;
        end
      end
      diag_pkg::div_run:
      begin
        next_dv_q = {dv_q[30:0], dv_t >= {1'b0, dv_d}};
        next_dv_r = dv_t >= {1'b0, dv_d} ? dv_t - {1'b0, dv_d} : dv_t;
        next_dv_n = dv_n - 6'h01;
        if (dv_n == 6'h01)
        begin
          next_div_state = diag_pkg::div_idle;
          if (!freeze_rise)
            next_live_avg = next_dv_q[15:0];
        end
      end
      default:
        next_div_state = diag_pkg::div_idle;
    endcase
    // a freeze drops the division of old sums
    if (freeze_rise)
      next_div_state = diag_pkg::div_idle;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_state <= diag_pkg::div_idle;
      dv_q      <= 32'h00000000;
      dv_r      <= 17'h00000;
      dv_d      <= 16'h0000;
      dv_n      <= 6'h00;
      live_avg  <= 16'h0000;
    end
    else
    begin
      div_state <= next_div_state;
      dv_q      <= next_dv_q;
      dv_r      <= next_dv_r;
      dv_d      <= next_dv_d;
      dv_n      <= next_dv_n;
      live_avg  <= next_live_avg;
    end
  end

  // histogram scan: peak per region, valley height at slicer bins
  logic [15:0] peak [4];
  logic [15:0] vly  [3];
  logic [15:0] next_peak [4];
  logic [15:0] next_vly  [3];
  logic        hist_done, next_hist_done;
  logic [1:0]  reg_i;
  always_comb
  begin
    next_peak      = peak;
    next_vly       = vly;
    next_hist_done = hist_valid & hist_last;
    reg_i          = hist_bin < valley_bin0 ? 2'h0 : hist_bin < valley_bin1 ? 2'h1
                   : hist_bin < valley_bin2 ? 2'h2 : 2'h3;
    if (hist_valid && hist_first)
    begin
      next_peak = '{default: 16'h0000};
      next_vly  = '{default: 16'h0000};
    end
    if (hist_valid)
    begin
      if (hist_bin == valley_bin0)
        next_vly[0] = hist_count;
      else if (hist_bin == valley_bin1)
        next_vly[1] = hist_count;
      else if (hist_bin == valley_bin2)
        next_vly[2] = hist_count;
      else if (hist_count > next_peak[reg_i])
        next_peak[reg_i] = hist_count;
    end
  end

  // metric calculators, one per quantity
  logic [15:0] snr_raw, ltp_raw;
  logic [15:0] mu [4];
  logic [15:0] sg [4];
  logic [17:0] snr_num [3];
  logic [17:0] snr_den [3];
  logic [17:0] ltp_num [3];
  logic [17:0] ltp_den [3];
  assign mu = '{lvl_mean0, lvl_mean1, lvl_mean2, lvl_mean3};
  assign sg = '{lvl_sigma0, lvl_sigma1, lvl_sigma2, lvl_sigma3};
  for (genvar i = 0; i < 3; i++)
  begin : g_eye
    // an inverted level pair gives a zero ratio, reported as 0 dB
    assign snr_num[i] = mu[i+1] > mu[i] ? {2'h0, mu[i+1] - mu[i]} : 18'h00000;
    assign snr_den[i] = {2'h0, sg[i+1]} + {2'h0, sg[i]};
    assign ltp_num[i] = {2'h0, peak[i+1]} + {2'h0, peak[i]};
    assign ltp_den[i] = {1'b0, vly[i], 1'b0};
  end

  eye_metric u_snr (
    .num0   (snr_num[0]),
    .num1   (snr_num[1]),
    .num2   (snr_num[2]),
    .den0   (snr_den[0]),
    .den1   (snr_den[1]),
    .den2   (snr_den[2]),
    .metric (snr_raw)
  );

  eye_metric u_ltp (
    .num0   (ltp_num[0]),
    .num1   (ltp_num[1]),
    .num2   (ltp_num[2]),
    .den0   (ltp_den[0]),
    .den1   (ltp_den[1]),
    .den2   (ltp_den[2]),
    .metric (ltp_raw)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      peak                    <= '{default: 16'h0000};
      vly                     <= '{default: 16'h0000};
      hist_done               <= 1'b0;
      electrical_eye_snr      <= 16'h0000;
      level_transition_metric <= 16'h0000;
    end
    else
    begin
      peak      <= next_peak;
      vly       <= next_vly;
      hist_done <= next_hist_done;
      if (snr_valid)
        electrical_eye_snr <= snr_raw;
      if (hist_done)
        level_transition_metric <= ltp_raw;
    end
  end
endmodule : diag_monitor_pages

// file: diag_pkg.sv
/*
  Constants shared by the extended diagnostics monitor: APB map,
  page numbers, byte positions inside the pages, field layouts,
  threshold defaults and metric encodings.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package diag_pkg;
  // apb map: page selector word, then a 128-word byte window
  localparam logic [11:0] ADDR_PAGE_SEL = 12'h000;
  localparam logic [11:0] ADDR_WIN_BASE = 12'h200;
  localparam logic [11:0] ADDR_WIN_LAST = 12'h3fc;
  localparam int          BANK_LSB      = 8;
  // page numbers
  localparam logic [7:0]  PAGE_ADVERT   = 8'h01;
  localparam logic [7:0]  PAGE_DESC0    = 8'h20;
  localparam logic [7:0]  PAGE_SAMP0    = 8'h24;
  localparam logic [7:0]  PAGE_THR0     = 8'h28;
  localparam logic [7:0]  PAGE_FLAG     = 8'h2c;
  localparam logic [7:0]  PAGE_MASK     = 8'h2d;
  localparam logic [7:0]  PAGE_CTRL     = 8'h2f;
  // byte positions within the upper page (byte 128 is index 0)
  localparam logic [6:0]  ADVERT_BYTE   = 7'h0e;
  localparam int          ADVERT_BIT    = 6;
  localparam logic [6:0]  FREEZE_BYTE   = 7'h10;
  localparam int          FREEZE_BIT    = 7;
  localparam logic [6:0]  STAT_BYTE0    = 7'h20;
  localparam logic [6:0]  SNR_BYTE0     = 7'h26;
  localparam logic [6:0]  LTP_BYTE0     = 7'h28;
  // descriptor: observable id in high byte, threshold set in low bits
  localparam int          SET_W         = 6;
  // threshold order inside a quad, also flag bit order
  localparam logic [1:0]  THR_HI_ALARM  = 2'h0;
  localparam logic [1:0]  THR_LO_ALARM  = 2'h1;
  localparam logic [1:0]  THR_HI_WARN   = 2'h2;
  localparam logic [1:0]  THR_LO_WARN   = 2'h3;
  localparam logic [15:0] THR_MAX       = 16'hffff;
  localparam logic [15:0] THR_MIN       = 16'h0000;
  // metric encoding
  localparam logic [15:0] METRIC_INF    = 16'hffff;
  localparam logic [15:0] METRIC_SAT    = 16'hfffe;
  localparam logic [9:0]  DB_PER_LOG2   = 10'h303;
  localparam int          FRAC_W        = 8;
  typedef enum logic {div_idle, div_run} div_state_t;
endpackage : diag_pkg

// file: eye_metric.sv
/*
  Ten times log10 of the smallest of three ratios num_i/den_i,
  in 1/256 dB, as used for eye snr and level transition values.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module eye_metric (
  input  wire logic [17:0] num0,
  input  wire logic [17:0] num1,
  input  wire logic [17:0] num2,
  input  wire logic [17:0] den0,
  input  wire logic [17:0] den1,
  input  wire logic [17:0] den2,
  output logic      [15:0] metric
);
  // log2 in q5.8: msb position plus the next eight bits, linear
  // mantissa keeps it cheap at the cost of up to about 0.3 dB error
  function automatic logic [12:0] log2q(input logic [17:0] x);
    logic [4:0]  p;
    logic [17:0] sh;
    p = 5'h00;
    for (int i = 0; i < 18; i++)
      if (x[i])
        p = 5'(i);
    sh = x << (5'h11 - p);
    return {p, sh[16:9]};
  endfunction : log2q

  logic [17:0]        num [3];
  logic [17:0]        den [3];
  logic signed [13:0] diff;
  logic               found;
  logic signed [13:0] cand;
  logic [23:0]        prod;

  assign num[0] = num0;
  assign num[1] = num1;
  assign num[2] = num2;
  assign den[0] = den0;
  assign den[1] = den1;
  assign den[2] = den2;

  // a zero denominator is an infinite ratio and never the minimum
  always_comb
  begin
    diff  = 14'sh0000;
    found = 1'b0;
    cand  = 14'sh0000;
    prod  = 24'h000000;
    for (int i = 0; i < 3; i++)
      if (den[i] != 18'h00000)
      begin
        cand = num[i] == 18'h00000 ? -14'sh1fff
             : $signed({1'b0, log2q(num[i])}) - $signed({1'b0, log2q(den[i])});
        if (!found || cand < diff)
          diff = cand;
        found = 1'b1;
      end
    if (diff > 14'sh0000)
      prod = 24'(diff) * 24'(diag_pkg::DB_PER_LOG2);
    if (!found)
      metric = diag_pkg::METRIC_INF;
    else if (prod[23:diag_pkg::FRAC_W] > 16'(diag_pkg::METRIC_SAT))
      metric = diag_pkg::METRIC_SAT;
    else
      metric = prod[diag_pkg::FRAC_W +: 16];
  end
endmodule : eye_metric

// file: diag_monitor_pages_monitor.sv
/* checker on the diag_monitor_pages ports
   assumes one pclk domain; bound at the foot */
`timescale 1ns/1ps
module diag_mon (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        management_init_state,
  input wire logic        irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle; decode is judged in the access after it
  wire setup = psel && !penable;
  sequence init_s;
    management_init_state [*2] ##0 !irq_request;
  endsequence
  a_no_wait: assert property (pready == penable) else $error("wait state seen");
  a_err_access: assert property (pslverr |-> penable) else $error("error outside access");
  a_odd_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr) else $error("odd address taken");
  a_high_err: assert property (setup && paddr > 12'h3fc |=> pslverr) else $error("high address taken");
  a_win_ok: assert property (setup && paddr[11:9] == 3'h1 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("window refused");
  a_sel_ok: assert property (setup && paddr == 12'h000 |=> !pslverr) else $error("select refused");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data not zero");
  a_init_quiet: assert property (init_s |=> !irq_request)
    else $error("flag raised in init");
endmodule : diag_mon
bind diag_monitor_pages diag_mon i_diag_mon (.*);

// file: apb_host.sv
/* apb host model, one transfer per call
   assumes a slave that raises pready */
`timescale 1ns/1ps
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic      [11:0] paddr = 12'h0,
  output logic      [31:0] pwdata = 32'h0,
  output logic      [3:0]  pstrb = 4'h0
);
  // hold the request until pready; released lines show the inverse
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready)
      @(posedge pclk);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    pstrb <= 4'h0;
  endtask : xfer
endmodule : apb_host

// file: tb.sv
/* bench for diag_monitor_pages with queued expectations
   assumes apb_host on the bus and the bound diag_mon */
`timescale 1ns/1ps
module tb;
  logic        pclk = 1'b0, presetn = 1'b0, management_init_state = 1'b0, hist_valid = 1'b0, hist_first = 1'b0;
  logic        desc_we = 1'b0, thr_we = 1'b0, samp_valid = 1'b0, fine_valid = 1'b0, snr_valid = 1'b0, hist_last = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq_request;
  logic [7:0]  sl = 8'h0, thr_index = 8'h0, hist_bin = 8'h0, vb = 8'h0;
  logic [15:0] dv = 16'h0, lv = 16'h0, sg = 16'h0, hist_count = 16'h0, v, electrical_eye_snr, level_transition_metric;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [32:0] rr, q[$];
  int          err_count = 0, cmp_count = 0, seed = 54;
  event        got;
  apb_host i_apb_host (.*);
  diag_monitor_pages i_diag_monitor_pages (.*, .desc_slot(sl), .samp_slot(sl), .desc_value(dv), .thr_value(dv),
    .samp_value(dv), .fine_value(dv), .lvl_mean0(16'h0), .lvl_mean1(lv), .lvl_mean2(lv << 1), .lvl_mean3(lv << 2),
    .lvl_sigma0(sg), .lvl_sigma1(sg), .lvl_sigma2(sg), .lvl_sigma3(sg), .valley_bin0(vb),
    .valley_bin1(vb + 8'h2), .valley_bin2(vb + 8'h4));
  // 100 ns period
  always #50 pclk = ~pclk;
  // page byte access; reads note the expected byte first
  task acc(input logic w, input logic [7:0] p, input logic [6:0] i, input logic [7:0] d);
    i_apb_host.xfer(1'b1, 12'h000, {24'h0, p}, rr);
    if (!w)
      q.push_back({25'h0, d});
    i_apb_host.xfer(w, 12'h200 + {3'h0, i, 2'h0}, {24'h0, d}, rr);
    if (!w)
      ->got;
  endtask : acc
  // direct output compare
  task ck(input logic [15:0] a, input logic [15:0] e);
    q.push_back({17'h0, e});
    rr = {17'h0, a};
    ->got;
  endtask : ck
  // one strobe beat: desc, thr, samp, fine, snr
  task beat(input logic [4:0] k, input logic [15:0] d);
    @(posedge pclk);
    {desc_we, thr_we, samp_valid, fine_valid, snr_valid} <= k;
    dv <= d;
    @(posedge pclk);
    {desc_we, thr_we, samp_valid, fine_valid, snr_valid} <= 5'h0;
  endtask : beat
  // oldest note against each result
  always @(got)
  begin
    cmp_count++;
    if (rr !== q[0])
    begin
      err_count++;
      $display("wrong value at %0t got %h want %h", $time, rr, q[0]);
    end
    void'(q.pop_front());
  end
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, 8'h01, 7'h0e, 8'h40);
    q.push_back({1'b1, 32'h0});
    i_apb_host.xfer(1'b0, 12'h403, 32'h0, rr);
    ->got;
    sl <= 8'h3;
    beat(5'h10, 16'h1205);
    thr_index <= 8'h14;
    beat(5'h08, 16'h0100);
    thr_index <= 8'h16;
    beat(5'h08, 16'h0080);
    acc(1'b0, 8'h20, 7'h06, 8'h12);
    acc(1'b0, 8'h20, 7'h07, 8'h05);
    acc(1'b0, 8'h20, 7'h08, 8'h00);
    acc(1'b0, 8'h28, 7'h00, 8'hff);
    acc(1'b0, 8'h28, 7'h2d, 8'h80);
    i_apb_host.xfer(1'b1, 12'h000, 32'h00000120, rr);
    q.push_back(33'h0);
    i_apb_host.xfer(1'b0, 12'h218, 32'h0, rr);
    ->got;
    $display("map test done");
    v = 16'h0101 + 16'($random(seed) & 32'h3fff);
    management_init_state <= 1'b1;
    beat(5'h04, v);
    acc(1'b0, 8'h2c, 7'h01, 8'h00);
    management_init_state <= 1'b0;
    beat(5'h04, v);
    repeat (2) @(negedge pclk);
    ck({15'h0, irq_request}, 16'h1);
    acc(1'b0, 8'h24, 7'h06, v[15:8]);
    acc(1'b0, 8'h2c, 7'h01, 8'h50);
    acc(1'b0, 8'h2c, 7'h01, 8'h00);
    acc(1'b1, 8'h2d, 7'h01, 8'h50);
    beat(5'h04, v);
    repeat (2) @(negedge pclk);
    ck({15'h0, irq_request}, 16'h0);
    $display("flag test done");
    beat(5'h02, 16'h0030);
    beat(5'h02, 16'h0010);
    acc(1'b1, 8'h2f, 7'h10, 8'h80);
    beat(5'h02, 16'h0005);
    beat(5'h04, 16'h0077);
    acc(1'b0, 8'h24, 7'h07, 8'h77);
    acc(1'b0, 8'h2f, 7'h21, 8'h10);
    acc(1'b0, 8'h2f, 7'h23, 8'h30);
    acc(1'b1, 8'h2f, 7'h10, 8'h00);
    acc(1'b0, 8'h2f, 7'h21, 8'h05);
    $display("stats test done");
    lv <= 16'h0100;
    beat(5'h01, 16'h0);
    @(negedge pclk);
    ck(electrical_eye_snr, 16'hffff);
    @(posedge pclk);
    sg <= 16'h0010;
    beat(5'h01, 16'h0);
    @(negedge pclk);
    ck(electrical_eye_snr, 16'(3 * diag_pkg::DB_PER_LOG2));
    @(posedge pclk);
    vb <= 8'h1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      hist_valid <= 1'b1;
      hist_first <= i == 0;
      hist_last <= i == 7;
      hist_bin <= 8'(i);
      hist_count <= i[0] ? 16'h0 : 16'h0040 + 16'($random(seed) & 32'hff);
    end
    @(posedge pclk);
    hist_valid <= 1'b0;
    repeat (3) @(negedge pclk);
    ck(level_transition_metric, 16'hffff);
    $display("eye test done");
    @(negedge pclk);
    close_out;
  end
  // cut a hang short
  initial
  begin
    repeat (3000) @(posedge pclk);
    err_count++;
    close_out;
  end
endmodule : tb
